// [hdl/afc_pkg.sv]
package afc_pkg;

  localparam int DATA_W    = 5;
  localparam int DEV_WORDS = 16;
  localparam int BUF_DEPTH = 8;

  localparam int CLK_PERIOD_NS     = 25;
  localparam int LOAD_HIGH_MIN_NS  = 25;
  localparam int LOAD_PERIOD_NS    = 100;
  localparam int UNLOAD_LOW_MIN_NS = 7;
  localparam int CLEAR_LOW_NS      = 40;
  localparam int CLEAR_RECOVER_NS  = 115;

  localparam int HALF_PERIOD_I = (LOAD_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOAD_HIGH_I   = (LOAD_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int UNLOAD_LOW_I  = (UNLOAD_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [2:0] LOAD_HIGH_CYC     = 3'((LOAD_HIGH_I > HALF_PERIOD_I) ?
                                                LOAD_HIGH_I : HALF_PERIOD_I);
  localparam logic [2:0] LOAD_LOW_CYC      = 3'(HALF_PERIOD_I);
  localparam logic [2:0] UNLOAD_LOW_CYC    = 3'((UNLOAD_LOW_I > HALF_PERIOD_I) ?
                                                UNLOAD_LOW_I : HALF_PERIOD_I);
  localparam logic [2:0] UNLOAD_HIGH_CYC   = 3'(HALF_PERIOD_I);
  localparam logic [2:0] CLEAR_LOW_CYC     = 3'((CLEAR_LOW_NS + CLK_PERIOD_NS - 1)
                                                / CLK_PERIOD_NS);
  localparam logic [2:0] CLEAR_RECOVER_CYC = 3'((CLEAR_RECOVER_NS + CLK_PERIOD_NS - 1)
                                                / CLK_PERIOD_NS);

  localparam logic [DATA_W-1:0] DATA_RST = 5'h00;

  typedef struct packed {
    logic              load_clock_a;
    logic              load_clock_b;
    logic              unload_strobe_in;
    logic              store_clear_n;
    logic              out_enable_n;
    logic [DATA_W-1:0] data;
  } afc_dev_out_t;

  typedef struct packed {
    logic              space_available;
    logic              output_valid;
    logic [DATA_W-1:0] q;
  } afc_dev_in_t;

  typedef enum logic [1:0] {W_IDLE, W_SETUP, W_HIGH, W_LOW} afc_wr_state_t;
  typedef enum logic [1:0] {R_WAIT, R_LOW, R_HIGH}          afc_rd_state_t;
  typedef enum logic [1:0] {C_IDLE, C_LOW, C_RECOVER}       afc_clr_state_t;

endpackage : afc_pkg

// [hdl/afc_word_fifo.sv]
`timescale 1ns/100ps
module afc_word_fifo #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             flush,
  input  wire logic [WIDTH-1:0] in_word,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_word,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  logic [AW:0]      nxt_count;
  logic             in_ready_ff;
  logic             out_valid_ff;
  wire              push = in_valid && in_ready_ff;
  wire              pop  = out_valid_ff && out_ready;

  assign nxt_count = flush ? '0 : count_ff + (AW+1)'(push) - (AW+1)'(pop);
  assign in_ready  = in_ready_ff;
  assign out_valid = out_valid_ff;
  assign out_word  = mem_ff[rd_ptr_ff];

  // Per-entry storage
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge ref_clk) begin
      if (push && wr_ptr_ff == AW'(i)) mem_ff[i] <= in_word;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || flush) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (push) wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
      if (pop)  rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      count_ff     <= '0;
      in_ready_ff  <= 1'b1;
      out_valid_ff <= 1'b0;
    end else begin
      count_ff     <= nxt_count;
      in_ready_ff  <= nxt_count != (AW+1)'(DEPTH);
      out_valid_ff <= nxt_count != '0;
    end
  end
endmodule : afc_word_fifo

// [hdl/afc_host.sv]
// What this block does
// - Producer clocks one input, holds other high
// - Strobes run at most ten megahertz
// - Load high 50 ns, unload low 50 ns
`timescale 1ns/100ps
module afc_host (
  input  wire logic                            ref_clk,
  input  wire logic                            rst,
  input  wire logic [afc_pkg::DATA_W-1:0]      wr_word,
  input  wire logic                            wr_valid,
  output logic                                 wr_ready,
  output logic [afc_pkg::DATA_W-1:0]           rd_word,
  output logic                                 rd_valid,
  input  wire logic                            rd_ready,
  input  wire logic                            clear_req,
  output logic                                 clear_busy,
  output afc_pkg::afc_dev_out_t                dev_out,
  input  wire afc_pkg::afc_dev_in_t            dev_in
);
  afc_pkg::afc_dev_out_t          dev_out_ff;
  afc_pkg::afc_wr_state_t         wr_state_ff;
  afc_pkg::afc_wr_state_t         nxt_wr_state;
  afc_pkg::afc_rd_state_t         rd_state_ff;
  afc_pkg::afc_rd_state_t         nxt_rd_state;
  afc_pkg::afc_clr_state_t        clr_state_ff;
  afc_pkg::afc_clr_state_t        nxt_clr_state;
  logic [2:0]                     wr_cnt_ff;
  logic [2:0]                     rd_cnt_ff;
  logic [2:0]                     clr_cnt_ff;
  logic                           clear_pend_ff;
  logic                           valid_seen_ff;
  logic [afc_pkg::DATA_W-1:0]     rd_word_ff;
  logic                           rd_valid_ff;
  logic                           clear_busy_ff;
  logic [afc_pkg::DATA_W-1:0]     buf_word;
  logic                           buf_valid;

  wire quiet      = clr_state_ff == afc_pkg::C_IDLE && !clear_pend_ff;
  wire wr_start   = wr_state_ff == afc_pkg::W_IDLE && buf_valid && quiet
                    && dev_in.space_available;
  wire rd_start   = rd_state_ff == afc_pkg::R_WAIT && quiet && !rd_valid_ff
                    && dev_in.output_valid && valid_seen_ff;
  wire clr_start  = clr_state_ff == afc_pkg::C_IDLE && clear_pend_ff
                    && wr_state_ff == afc_pkg::W_IDLE && rd_state_ff == afc_pkg::R_WAIT;
  wire wr_hi_done = wr_cnt_ff == afc_pkg::LOAD_HIGH_CYC - 3'h1;
  wire wr_lo_done = wr_cnt_ff == afc_pkg::LOAD_LOW_CYC - 3'h1;
  wire rd_lo_done = rd_cnt_ff == afc_pkg::UNLOAD_LOW_CYC - 3'h1;
  wire rd_hi_done = rd_cnt_ff == afc_pkg::UNLOAD_HIGH_CYC - 3'h1;
  wire cl_lo_done = clr_cnt_ff == afc_pkg::CLEAR_LOW_CYC - 3'h1;
  wire cl_rc_done = clr_cnt_ff == afc_pkg::CLEAR_RECOVER_CYC - 3'h1;

  afc_word_fifo #(
    .WIDTH (afc_pkg::DATA_W),
    .DEPTH (afc_pkg::BUF_DEPTH)
  ) u_buf (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .flush     (clr_start),
    .in_word   (wr_word),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .out_word  (buf_word),
    .out_valid (buf_valid),
    .out_ready (wr_start)
  );

  // Load sequencer
  always_comb begin
    nxt_wr_state = wr_state_ff;
    unique case (wr_state_ff)
      afc_pkg::W_IDLE:  if (wr_start) nxt_wr_state = afc_pkg::W_SETUP;
      afc_pkg::W_SETUP: nxt_wr_state = afc_pkg::W_HIGH;
      afc_pkg::W_HIGH:  if (wr_hi_done) nxt_wr_state = afc_pkg::W_LOW;
      afc_pkg::W_LOW:   if (wr_lo_done) nxt_wr_state = afc_pkg::W_IDLE;
    endcase
  end

  // Unload sequencer
  always_comb begin
    nxt_rd_state = rd_state_ff;
    unique case (rd_state_ff)
      afc_pkg::R_WAIT: if (rd_start) nxt_rd_state = afc_pkg::R_LOW;
      afc_pkg::R_LOW:  if (rd_lo_done) nxt_rd_state = afc_pkg::R_HIGH;
      afc_pkg::R_HIGH: if (rd_hi_done) nxt_rd_state = afc_pkg::R_WAIT;
    endcase
  end

  // Clear sequencer
  always_comb begin
    nxt_clr_state = clr_state_ff;
    unique case (clr_state_ff)
      afc_pkg::C_IDLE:    if (clr_start) nxt_clr_state = afc_pkg::C_LOW;
      afc_pkg::C_LOW:     if (cl_lo_done) nxt_clr_state = afc_pkg::C_RECOVER;
      afc_pkg::C_RECOVER: if (cl_rc_done) nxt_clr_state = afc_pkg::C_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_state_ff  <= afc_pkg::W_IDLE;
      rd_state_ff  <= afc_pkg::R_WAIT;
      clr_state_ff <= afc_pkg::C_IDLE;
      wr_cnt_ff    <= 3'h0;
      rd_cnt_ff    <= 3'h0;
      clr_cnt_ff   <= 3'h0;
    end else begin
      wr_state_ff  <= nxt_wr_state;
      rd_state_ff  <= nxt_rd_state;
      clr_state_ff <= nxt_clr_state;
      wr_cnt_ff    <= (nxt_wr_state != wr_state_ff) ? 3'h0 : wr_cnt_ff + 3'h1;
      rd_cnt_ff    <= (nxt_rd_state != rd_state_ff) ? 3'h0 : rd_cnt_ff + 3'h1;
      clr_cnt_ff   <= (nxt_clr_state != clr_state_ff) ? 3'h0 : clr_cnt_ff + 3'h1;
    end
  end

  // Pin drive
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dev_out_ff.load_clock_a     <= 1'b0;
      dev_out_ff.load_clock_b     <= 1'b1;
      dev_out_ff.unload_strobe_in <= 1'b1;
      dev_out_ff.store_clear_n    <= 1'b1;
      dev_out_ff.out_enable_n     <= 1'b0;
      dev_out_ff.data             <= afc_pkg::DATA_RST;
    end else begin
      dev_out_ff.load_clock_a     <= nxt_wr_state == afc_pkg::W_HIGH;
      dev_out_ff.load_clock_b     <= 1'b1;
      dev_out_ff.unload_strobe_in <= nxt_rd_state != afc_pkg::R_LOW;
      dev_out_ff.store_clear_n    <= nxt_clr_state != afc_pkg::C_LOW;
      dev_out_ff.out_enable_n     <= 1'b0;
      if (wr_start) dev_out_ff.data <= buf_word;
    end
  end

  // Read capture
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_word_ff    <= afc_pkg::DATA_RST;
      rd_valid_ff   <= 1'b0;
      valid_seen_ff <= 1'b0;
      clear_pend_ff <= 1'b0;
      clear_busy_ff <= 1'b0;
    end else begin
      valid_seen_ff <= dev_in.output_valid && rd_state_ff == afc_pkg::R_WAIT;
      if (rd_start) begin
        rd_word_ff  <= dev_in.q;
        rd_valid_ff <= 1'b1;
      end else if (rd_ready) begin
        rd_valid_ff <= 1'b0;
      end
      clear_pend_ff <= clear_req || (clear_pend_ff && !clr_start);
      clear_busy_ff <= clear_req || clear_pend_ff || nxt_clr_state != afc_pkg::C_IDLE;
    end
  end

  assign dev_out    = dev_out_ff;
  assign rd_word    = rd_word_ff;
  assign rd_valid   = rd_valid_ff;
  assign clear_busy = clear_busy_ff;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_load_pulse;
    dev_out_ff.load_clock_a [*2] ##1 !dev_out_ff.load_clock_a [*2];
  endsequence

  sequence s_unload_pulse;
    !dev_out_ff.unload_strobe_in [*2] ##1 dev_out_ff.unload_strobe_in [*2];
  endsequence

  chk_load_needs_space: assert property (
    $rose(dev_out_ff.load_clock_a) |-> $past(dev_in.space_available, 2))
    else $error("load clock rose without space available");

  chk_gate_held_high: assert property (
    dev_out_ff.load_clock_b)
    else $error("second load clock not held high");

  chk_load_shape: assert property (
    $rose(dev_out_ff.load_clock_a) |-> s_load_pulse)
    else $error("load pulse width or period wrong");

  chk_load_data_held: assert property (
    $rose(dev_out_ff.load_clock_a) |-> $stable(dev_out_ff.data) [*4])
    else $error("load data moved around load edge");

  chk_unload_shape: assert property (
    $fell(dev_out_ff.unload_strobe_in) |-> s_unload_pulse)
    else $error("unload strobe pulse wrong");

  chk_unload_on_valid: assert property (
    $fell(dev_out_ff.unload_strobe_in) |->
      $past(dev_in.output_valid) && $past(dev_in.output_valid, 2))
    else $error("unload without settled output valid");

  chk_capture_word: assert property (
    $rose(rd_valid_ff) |-> rd_word_ff == $past(dev_in.q))
    else $error("captured word differs from device outputs");

  chk_clear_pulse: assert property (
    $fell(dev_out_ff.store_clear_n) |->
      !dev_out_ff.store_clear_n [*2] ##1 dev_out_ff.store_clear_n [*5])
    else $error("clear pulse or recovery wrong");

  chk_no_load_clearing: assert property (
    !dev_out_ff.store_clear_n |->
      (!dev_out_ff.load_clock_a && dev_out_ff.unload_strobe_in) [*7])
    else $error("load or unload during clear or recovery");

  chk_output_enabled: assert property (
    !dev_out_ff.out_enable_n)
    else $error("device outputs not enabled");
endmodule : afc_host

// [test/afc_dev_model.sv]
`timescale 1ns/100ps
module afc_dev_model (
  input  wire logic                       load_clock_a,
  input  wire logic                       load_clock_b,
  input  wire logic                       unload_strobe_in,
  input  wire logic                       store_clear_n,
  input  wire logic                       out_enable_n,
  input  wire logic [afc_pkg::DATA_W-1:0] data,
  output logic                            space_available,
  output logic                            output_valid,
  output logic                            unload_pulse_out,
  output logic [afc_pkg::DATA_W-1:0]      q
);
  logic [afc_pkg::DATA_W-1:0] mem [16];
  logic [3:0]                 wp = 4'h0;
  logic [3:0]                 rp = 4'h0;
  int                         cnt = 0;
  logic                       vis = 1'b0;
  bit                         slow = 1'b0;

  initial unload_pulse_out = 1'b1;

  task automatic load_word();
    if (cnt < 16) begin
      mem[wp] = data;
      wp++;
      cnt++;
    end
  endtask : load_word

  // Separate processes per side
  always @(posedge load_clock_a) if (load_clock_b) load_word();
  always @(posedge load_clock_b) if (load_clock_a) load_word();

  always @(posedge unload_strobe_in) begin
    if (cnt > 0 && store_clear_n) begin
      if (cnt == 16) begin
        unload_pulse_out = 1'b0;
        unload_pulse_out <= #14 1'b1;
      end
      rp++;
      cnt--;
      vis = 1'b0;
    end
  end

  // Fall-through to first location, prompt or slow
  always @(cnt or vis) if (!vis && cnt > 0) vis <= #(slow ? 80 : 10) 1'b1;

  assign output_valid    = vis && cnt > 0 && unload_strobe_in;
  assign space_available = cnt < 16;
  assign q = out_enable_n ? 'z : (output_valid ? mem[rp] : ~mem[rp]);

  always @(negedge store_clear_n) begin
    cnt = 0;
    wp  = 4'h0;
    rp  = 4'h0;
    vis = 1'b0;
  end
endmodule : afc_dev_model

// [test/tb.sv]
`timescale 1ns/100ps
module tb;
  logic                       ref_clk   = 1'b0;
  logic                       rst       = 1'b1;
  logic [afc_pkg::DATA_W-1:0] wr_word   = 5'h00;
  logic                       wr_valid  = 1'b0;
  logic                       rd_ready  = 1'b0;
  logic                       clear_req = 1'b0;
  logic                       wr_ready;
  logic                       rd_valid;
  logic                       clear_busy;
  logic [afc_pkg::DATA_W-1:0] rd_word;
  afc_pkg::afc_dev_out_t      dev_out;
  afc_pkg::afc_dev_in_t       dev_in;
  logic                       dev_space;
  logic                       dev_ovalid;
  logic [afc_pkg::DATA_W-1:0] dev_q;
  int                         failures    = 0;
  int                         check_count = 0;
  int                         clr_seen    = 0;
  realtime                    last_ld     = 0.0;
  logic [afc_pkg::DATA_W-1:0] got [$];

  afc_host dut (.ref_clk(ref_clk), .rst(rst), .wr_word(wr_word), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .rd_word(rd_word), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .clear_req(clear_req), .clear_busy(clear_busy), .dev_out(dev_out), .dev_in(dev_in));

  afc_dev_model dev (.load_clock_a(dev_out.load_clock_a), .load_clock_b(dev_out.load_clock_b),
    .unload_strobe_in(dev_out.unload_strobe_in), .store_clear_n(dev_out.store_clear_n),
    .out_enable_n(dev_out.out_enable_n), .data(dev_out.data),
    .space_available(dev_space), .output_valid(dev_ovalid),
    .unload_pulse_out(), .q(dev_q));

  assign dev_in = {dev_space, dev_ovalid, dev_q};

  initial forever #12.5 ref_clk = ~ref_clk;

  task automatic summarize();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize

  task automatic check_w(input string nm, input logic [4:0] exp, input logic [4:0] act);
    check_count++;
    if (act !== exp) begin
      failures++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, act);
    end
  endtask : check_w

  task automatic check_b(input string nm, input logic exp, input logic act);
    check_count++;
    if (act !== exp) begin
      failures++;
      $display("wrong value %s expected %0b seen %0b", nm, exp, act);
    end
  endtask : check_b

  always @(posedge dev_out.load_clock_a) begin
    if (!rst && last_ld > 0.0) check_b("load spacing", 1'b1, ($realtime - last_ld) >= 100.0);
    last_ld = $realtime;
  end
  always @(negedge dev_out.load_clock_a)
    if (!rst) check_b("load high", 1'b1, ($realtime - last_ld) >= 25.0);
  always @(negedge dev_out.store_clear_n) if (!rst) clr_seen++;

  // Leaves wr_valid high when taken
  task automatic offer(input logic [4:0] w, input bit may_refuse, output bit ok);
    int n;
    n = 0;
    wr_word = w;
    wr_valid = 1'b1;
    while (wr_ready !== 1'b1 && n < 400) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    ok = (wr_ready === 1'b1);
    if (ok) begin
      @(posedge ref_clk);
      #1;
    end
    if (!ok && !may_refuse) begin
      failures++;
      summarize();
    end
  endtask : offer

  task automatic drain();
    int idle;
    idle = 0;
    rd_ready = 1'b1;
    while (idle < 60) begin
      if (rd_valid === 1'b1) begin
        got.push_back(rd_word);
        idle = 0;
      end
      @(posedge ref_clk);
      #1;
      idle++;
    end
    rd_ready = 1'b0;
  endtask : drain

  task automatic expect_seq(input logic [4:0] first, input int n);
    check_w("word count", 5'(n), 5'(got.size()));
    foreach (got[i]) check_w("word", 5'(first + i), got[i]);
    got.delete();
  endtask : expect_seq

  task automatic t_reset();
    check_b("gate held", 1'b1, dev_out.load_clock_b);
    check_b("strobe idle", 1'b1, dev_out.unload_strobe_in);
    check_b("enable", 1'b0, dev_out.out_enable_n);
    check_b("clear idle", 1'b1, dev_out.store_clear_n);
    check_b("load idle", 1'b0, dev_out.load_clock_a);
    check_b("rd_valid", 1'b0, rd_valid);
  endtask : t_reset

  task automatic t_fill();
    bit ok;
    int taken;
    taken = 0;
    for (int i = 0; i < 26; i++) begin
      offer(5'(i), i == 25, ok);
      if (ok) taken++;
    end
    wr_valid = 1'b0;
    check_w("capacity", 5'h19, 5'(taken));
    check_b("space", 1'b0, dev_in.space_available);
    drain();
    expect_seq(5'h00, 25);
  endtask : t_fill

  task automatic t_clear();
    bit ok;
    int n;
    for (int i = 0; i < 5; i++) offer(5'h10 + 5'(i), 1'b0, ok);
    wr_valid = 1'b0;
    n = 0;
    while (dev.cnt != 4 && n < 200) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (dev.cnt != 4) begin
      failures++;
      summarize();
    end
    clear_req = 1'b1;
    @(posedge ref_clk);
    #1;
    clear_req = 1'b0;
    n = 0;
    while (clear_busy !== 1'b0 && n < 50) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check_b("clear done", 1'b0, clear_busy);
    if (clear_busy !== 1'b0) summarize();
    check_w("clear pulses", 5'h01, 5'(clr_seen));
    check_w("device empty", 5'h00, 5'(dev.cnt));
    offer(5'h1A, 1'b0, ok);
    offer(5'h1B, 1'b0, ok);
    wr_valid = 1'b0;
    drain();
    check_w("kept word", 5'h10, got.pop_front());
    expect_seq(5'h1A, 2);
  endtask : t_clear

  task automatic t_slow();
    bit ok;
    dev.slow = 1'b1;
    for (int i = 0; i < 4; i++) offer(5'h05 + 5'(i), 1'b0, ok);
    wr_valid = 1'b0;
    drain();
    expect_seq(5'h05, 4);
    dev.slow = 1'b0;
  endtask : t_slow

  initial begin
    repeat (8) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    @(posedge ref_clk);
    #1;
    t_reset();
    t_fill();
    t_clear();
    t_slow();
    summarize();
  end
endmodule : tb
